// >>> design/spm_core.sv
// Serial port core: low-power modes, reset behaviour and interrupt logic
`timescale 1ns/10ps
`include "spm_params.svh"

module spm_core (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Power modes
  input wire logic I_WAIT,
  input wire logic I_STOP,
  // Serial pins
  input wire logic I_SCK,
  output logic O_SCK,
  output logic O_SCK_OE,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE,
  input wire logic I_SS_N,
  // Interrupt
  output logic O_IRQ
);
  import spm_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_n_s;
  spm_pin_sync #(.RST_VAL(1'b0)) u_sck (.i_clk(I_CLK_SYS), .i_rst(I_RST),
    .i_pin(I_SCK), .o_level(sck_s));
  spm_pin_sync #(.RST_VAL(1'b0)) u_mosi (.i_clk(I_CLK_SYS), .i_rst(I_RST),
    .i_pin(I_MOSI), .o_level(mosi_s));
  spm_pin_sync #(.RST_VAL(1'b0)) u_miso (.i_clk(I_CLK_SYS), .i_rst(I_RST),
    .i_pin(I_MISO), .o_level(miso_s));
  spm_pin_sync #(.RST_VAL(1'b1)) u_ss (.i_clk(I_CLK_SYS), .i_rst(I_RST),
    .i_pin(I_SS_N), .o_level(ss_n_s));

  // ==========================================================
  // State
  spm_state_t state_ff;
  spm_state_t nxt_state;
  logic en_ff;
  logic master_select_bit_ff;
  logic mfen_ff;
  logic wss_ff;
  logic [7:0] baud_ff;
  logic [2:0] mask_ff;
  logic cmpl_ff;
  logic temp_ff;
  logic mode_fault_flag_ff;
  logic arm_cmpl_ff;
  logic arm_mode_fault_flag_ff;
  logic [7:0] data_rx_ff;
  logic [7:0] tx_buf_ff;
  logic [7:0] rdata_ff;
  logic [7:0] sh_ff;
  logic cap_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] div_ff;
  logic sck_o_ff;
  logic sck_q_ff;
  logic ss_q_ff;
  logic lp_q_ff;
  logic echo_ff;
  logic pend_ff;
  logic [7:0] pend_byte_ff;

  // ==========================================================
  // Decode
  wire wr_c1 = I_WR && (I_ADDR == `SPM_ADDR_CTRL1);
  wire wr_c2 = I_WR && (I_ADDR == `SPM_ADDR_CTRL2);
  wire wr_baud = I_WR && (I_ADDR == `SPM_ADDR_BAUD);
  wire wr_st = I_WR && (I_ADDR == `SPM_ADDR_STATUS);
  wire wr_data = I_WR && (I_ADDR == `SPM_ADDR_DATA);
  wire wr_mask = I_WR && (I_ADDR == `SPM_ADDR_MASK);
  wire rd_st = I_RD && (I_ADDR == `SPM_ADDR_STATUS);
  wire rd_data = I_RD && (I_ADDR == `SPM_ADDR_DATA);
  wire [2:0] status = {mode_fault_flag_ff, temp_ff, cmpl_ff};

  // Stop always freezes; wait only when wait stop select is set
  wire lp = I_STOP || (I_WAIT && wss_ff);
  wire lp_exit = lp_q_ff && !lp;
  wire slave = en_ff && !master_select_bit_ff && !mode_fault_flag_ff;
  wire sck_rise = sck_s && !sck_q_ff;
  wire sck_fall = !sck_s && sck_q_ff;
  wire ss_fall = !ss_n_s && ss_q_ff;
  wire mode_fault_flag_set = en_ff && master_select_bit_ff && mfen_ff && !ss_n_s;
  // The synchronised return data lags about five clocks, so a master
  // half period shorter than that samples the previous bit
  wire div_hit = (div_ff == baud_ff);
  wire m_tick = (state_ff == SPM_RUN) && !lp && div_hit;
  wire m_rise = m_tick && !sck_o_ff;
  wire m_fall = m_tick && sck_o_ff;
  wire s_act = (state_ff == SPM_SLV) && !ss_n_s;
  // Slave edges are followed even in low power, keeping bit sync
  wire s_rise = s_act && sck_rise;
  wire s_fall = s_act && sck_fall;
  wire any_fall = m_fall || s_fall;
  wire last_bit = (bit_cnt_ff == (`SPM_BYTE_BITS - 4'h1));
  wire byte_done = any_fall && last_bit;
  wire [7:0] rx_byte = {sh_ff[6:0], cap_ff};
  wire m_start = (state_ff == SPM_IDLE) && en_ff && master_select_bit_ff && !temp_ff
    && !lp && !wr_data && !mode_fault_flag_set;
  wire s_start = slave && ss_fall;
  // Echo mode sends back the byte just taken in
  wire [7:0] s_reload = (lp && echo_ff) ? rx_byte : tx_buf_ff;
  wire s_takes_buf = s_start || (s_fall && last_bit && !lp);
  wire load_buf = m_start || s_takes_buf || (m_fall && last_bit && !temp_ff);
  wire copy_now = (byte_done && !lp) || (lp_exit && pend_ff);
  wire [7:0] copy_byte = (lp_exit && pend_ff) ? pend_byte_ff : rx_byte;
  // A frame that opens in echo mode starts with the last byte taken in
  wire [7:0] s_echo_byte = pend_ff ? pend_byte_ff : data_rx_ff;
  wire [7:0] s_first = (lp && echo_ff) ? s_echo_byte : tx_buf_ff;

  logic [7:0] rd_mux;
  assign rd_mux =
    (I_ADDR == `SPM_ADDR_CTRL1) ? {5'h00, mfen_ff, master_select_bit_ff, en_ff} :
    (I_ADDR == `SPM_ADDR_CTRL2) ? {7'h00, wss_ff} :
    (I_ADDR == `SPM_ADDR_BAUD) ? baud_ff :
    (I_ADDR == `SPM_ADDR_STATUS) ? {5'h00, status} :
    (I_ADDR == `SPM_ADDR_DATA) ? data_rx_ff :
    (I_ADDR == `SPM_ADDR_MASK) ? {5'h00, mask_ff} : `SPM_ZERO8;

  // ==========================================================
  // State machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SPM_IDLE: begin
        if (m_start) begin
          nxt_state = SPM_RUN;
        end else if (s_start) begin
          nxt_state = SPM_SLV;
        end
      end
      SPM_RUN: begin
        if (byte_done && temp_ff) begin
          nxt_state = SPM_IDLE;
        end
      end
      SPM_SLV: begin
        if (ss_n_s) begin
          nxt_state = SPM_IDLE;
        end
      end
      default: nxt_state = SPM_IDLE;
    endcase
    if (mode_fault_flag_set || !en_ff) begin
      nxt_state = SPM_IDLE;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      {mfen_ff, master_select_bit_ff, en_ff} <= `SPM_RST_CTRL1;
      wss_ff <= 1'b0;
      baud_ff <= `SPM_RST_BAUD;
      mask_ff <= `SPM_RST_MASK;
    end else begin
      if (wr_c1) begin
        en_ff <= I_WDATA[`SPM_C1_EN];
        mfen_ff <= I_WDATA[`SPM_C1_MFEN];
      end
      if (mode_fault_flag_set) begin
        master_select_bit_ff <= 1'b0;
      end else if (wr_c1) begin
        master_select_bit_ff <= I_WDATA[`SPM_C1_MASTER_SELECT_BIT];
      end
      if (wr_c2) begin
        wss_ff <= I_WDATA[`SPM_C2_WSS];
      end
      if (wr_baud) begin
        baud_ff <= I_WDATA;
      end
      if (wr_mask) begin
        mask_ff <= I_WDATA[2:0];
      end
    end
  end

  // ==========================================================
  // Flags; a set in the same cycle as a clear wins
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      cmpl_ff <= 1'b0;
      temp_ff <= 1'b1;
      mode_fault_flag_ff <= 1'b0;
      arm_cmpl_ff <= 1'b0;
      arm_mode_fault_flag_ff <= 1'b0;
    end else begin
      if (rd_st) begin
        arm_cmpl_ff <= cmpl_ff;
        arm_mode_fault_flag_ff <= mode_fault_flag_ff;
      end
      if (copy_now) begin
        cmpl_ff <= 1'b1;
      end else if ((rd_data && arm_cmpl_ff) ||
                   (wr_st && I_WDATA[`SPM_ST_CMPL])) begin
        cmpl_ff <= 1'b0;
        arm_cmpl_ff <= 1'b0;
      end
      if (load_buf) begin
        temp_ff <= 1'b1;
      end else if (wr_data || (wr_st && I_WDATA[`SPM_ST_TEMP])) begin
        temp_ff <= 1'b0;
      end
      if (mode_fault_flag_set) begin
        mode_fault_flag_ff <= 1'b1;
      end else if ((wr_c1 && arm_mode_fault_flag_ff) ||
                   (wr_st && I_WDATA[`SPM_ST_MODE_FAULT_FLAG])) begin
        mode_fault_flag_ff <= 1'b0;
        arm_mode_fault_flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Data registers
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      data_rx_ff <= `SPM_RST_DATA;
      tx_buf_ff <= `SPM_RST_DATA;
      rdata_ff <= `SPM_ZERO8;
    end else begin
      if (wr_data) begin
        tx_buf_ff <= I_WDATA;
      end
      if (copy_now) begin
        data_rx_ff <= copy_byte;
      end
      rdata_ff <= I_RD ? rd_mux : `SPM_ZERO8;
    end
  end

  // ==========================================================
  // Shifter; the shift register is not cleared by a data write, but a
  // slave selected loads tx_buf_ff, so before any write it sends zero
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state_ff <= SPM_IDLE;
      sh_ff <= `SPM_ZERO8;
      cap_ff <= 1'b0;
      bit_cnt_ff <= 4'h0;
      div_ff <= `SPM_ZERO8;
      sck_o_ff <= 1'b0;
      sck_q_ff <= 1'b0;
      ss_q_ff <= 1'b1;
      lp_q_ff <= 1'b0;
      echo_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_byte_ff <= `SPM_ZERO8;
    end else begin
      state_ff <= nxt_state;
      sck_q_ff <= sck_s;
      ss_q_ff <= ss_n_s;
      lp_q_ff <= lp;
      if (lp && !lp_q_ff) begin
        echo_ff <= temp_ff;
      end
      if (nxt_state != SPM_RUN) begin
        div_ff <= `SPM_ZERO8;
        sck_o_ff <= 1'b0;
      end else if (!lp) begin
        div_ff <= div_hit ? `SPM_ZERO8 : div_ff + 8'h01;
        sck_o_ff <= div_hit ? !sck_o_ff : sck_o_ff;
      end
      if (m_rise) begin
        cap_ff <= miso_s;
      end else if (s_rise) begin
        cap_ff <= mosi_s;
      end
      if (m_start) begin
        sh_ff <= tx_buf_ff;
        bit_cnt_ff <= 4'h0;
      end else if (s_start) begin
        sh_ff <= s_first;
        bit_cnt_ff <= 4'h0;
      end else if (any_fall) begin
        bit_cnt_ff <= last_bit ? 4'h0 : bit_cnt_ff + 4'h1;
        if (!last_bit) begin
          sh_ff <= rx_byte;
        end else if (s_fall) begin
          sh_ff <= s_reload;
        end else begin
          sh_ff <= tx_buf_ff;
        end
      end
      if (byte_done && lp) begin
        pend_ff <= 1'b1;
        pend_byte_ff <= rx_byte;
      end else if (lp_exit) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Pins and interrupt; all drivers drop while mode fault stands
  assign O_SCK = sck_o_ff;
  assign O_MOSI = sh_ff[7];
  assign O_MISO = sh_ff[7];
  assign O_SCK_OE = en_ff && master_select_bit_ff && !mode_fault_flag_ff;
  assign O_MOSI_OE = en_ff && master_select_bit_ff && !mode_fault_flag_ff;
  assign O_MISO_OE = slave && !ss_n_s;
  assign O_IRQ = en_ff && |(status & mask_ff);
  assign O_RDATA = rdata_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic got_ff;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      got_ff <= 1'b0;
    end else if (copy_now) begin
      got_ff <= 1'b1;
    end
  end

  sequence s_arm_mode_fault_flag;
    rd_st && mode_fault_flag_ff ##1 (!I_RD && !I_WR) ##1 (wr_c1 && !mode_fault_flag_set);
  endsequence
  sequence s_arm_cmpl;
    rd_st && cmpl_ff ##1 (!I_RD && !I_WR) ##1 (rd_data && !copy_now);
  endsequence

  property p_irq_en;
    !en_ff |-> !O_IRQ;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while off");
  property p_irq_or;
    en_ff && mode_fault_flag_ff && mask_ff[`SPM_ST_MODE_FAULT_FLAG] |-> O_IRQ;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not or");
  property p_mode_fault_flag;
    mode_fault_flag_set |=> !master_select_bit_ff && mode_fault_flag_ff && state_ff == SPM_IDLE;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("fault no abort");
  property p_mode_fault_flag_pins;
    mode_fault_flag_ff |-> !O_SCK_OE && !O_MOSI_OE && !O_MISO_OE;
  endproperty
  a_mode_fault_flag_pins: assert property (p_mode_fault_flag_pins) else $error("drive");
  property p_mode_fault_flag_clr;
    s_arm_mode_fault_flag |=> !mode_fault_flag_ff;
  endproperty
  a_mode_fault_flag_clr: assert property (p_mode_fault_flag_clr) else $error("fault kept");
  property p_cmpl_clr;
    s_arm_cmpl |=> !cmpl_ff;
  endproperty
  a_cmpl_clr: assert property (p_cmpl_clr) else $error("cmpl kept");
  property p_copy;
    byte_done && !lp |=> cmpl_ff && data_rx_ff == $past(rx_byte);
  endproperty
  a_copy: assert property (p_copy) else $error("no copy");
  property p_freeze;
    state_ff == SPM_RUN && lp ##1 state_ff == SPM_RUN && lp
      |-> $stable(sh_ff) && $stable(bit_cnt_ff) && $stable(O_SCK);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  property p_zero;
    !got_ff && rd_data |=> O_RDATA == `SPM_ZERO8;
  endproperty
  a_zero: assert property (p_zero) else $error("data not zero");
  property p_empty;
    load_buf |=> temp_ff;
  endproperty
  a_empty: assert property (p_empty) else $error("empty not set");
  property p_slv_lp;
    s_fall && !last_bit && lp |=> bit_cnt_ff == $past(bit_cnt_ff) + 4'h1;
  endproperty
  a_slv_lp: assert property (p_slv_lp) else $error("lost sync");
endmodule : spm_core

// >>> design/spm_params.svh
// Register offsets, field positions, reset values and widths of the block
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SPM_ADDR_CTRL1 8'h00
`define SPM_ADDR_CTRL2 8'h04
`define SPM_ADDR_BAUD 8'h08
`define SPM_ADDR_STATUS 8'h0C
`define SPM_ADDR_DATA 8'h10
`define SPM_ADDR_MASK 8'h14

// ==========================================================
// Field positions
`define SPM_C1_EN 0
`define SPM_C1_MASTER_SELECT_BIT 1
`define SPM_C1_MFEN 2
`define SPM_C2_WSS 0
`define SPM_ST_CMPL 0
`define SPM_ST_TEMP 1
`define SPM_ST_MODE_FAULT_FLAG 2

// ==========================================================
// Reset values and widths
`define SPM_RST_CTRL1 3'h0
`define SPM_RST_BAUD 8'h00
`define SPM_RST_MASK 3'h7
`define SPM_RST_DATA 8'h00
`define SPM_BYTE_BITS 4'h8
`define SPM_ZERO8 8'h00

`endif

// >>> design/spm_pkg.sv
// Types shared by the serial port core
package spm_pkg;
  typedef enum logic [2:0] {
    SPM_IDLE = 3'b001,
    SPM_RUN = 3'b010,
    SPM_SLV = 3'b100
  } spm_state_t;
endpackage : spm_pkg

// >>> design/spm_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module spm_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin and synchronised level
  input wire logic i_pin,
  output logic o_level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  // Level only moves once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
  assign o_level = level_ff;
endmodule : spm_pin_sync

// >>> verif/spm_partner.sv
// Far-side serial device: master by task call, slave on the block's clock
`timescale 1ns/10ps
module spm_partner (
  // Resolved pin levels
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  // Partner drivers
  output logic o_sck,
  output logic o_mosi,
  output logic o_miso,
  output logic o_ss_n
);
  logic [7:0] s_tx = 8'h00;
  logic [7:0] s_rx = 8'h00;

  // ==========================================================
  // Slave role: mode 0, MSB first, only while not acting as master
  assign o_miso = s_tx[7];
  always @(posedge i_sck) begin
    if (o_ss_n) s_rx <= {s_rx[6:0], i_mosi};
  end
  always @(negedge i_sck) begin
    if (o_ss_n) s_tx <= {s_tx[6:0], ~s_tx[0]};
  end

  task automatic load(input logic [7:0] d);
    s_tx = d;
  endtask : load

  // ==========================================================
  // Master role: clock runs only inside the frame
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
  end

  task automatic xfer(input logic [7:0] tx, input int hp,
                      output logic [7:0] rx);
    o_ss_n = 1'b0;
    o_mosi = tx[7];
    // Select leads the first edge so the synchroniser sees it first
    #(2 * hp);
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #hp o_sck = 1'b1;
      rx[i] = i_miso;
      #hp o_sck = 1'b0;
    end
    #hp o_ss_n = 1'b1;
    // Released data line must not keep looking valid
    o_mosi = ~o_mosi;
  endtask : xfer
endmodule : spm_partner

// >>> verif/spm_core_tb.sv
// Self-checking bench for the serial port core
`timescale 1ns/10ps
`include "spm_params.svh"
module spm_core_tb;
  typedef struct {logic [7:0] a; logic [7:0] e;} spm_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wt = 1'b0;
  logic stp = 1'b0;
  logic flt_n = 1'b1;
  logic [7:0] rx;
  logic [7:0] m;
  logic s;
  int fail_count = 0;
  int compares = 0;
  wire logic [7:0] rdata;
  wire logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq;
  wire logic p_sck, p_mosi, p_miso, p_ss_n;
  // Clock line carries the core's clock while it drives, else the partner's
  wire logic sck_w = sck_oe ? sck_o : p_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire logic miso_w = miso_oe ? miso_o : p_miso;
  spm_row_t rows [7] = '{'{`SPM_ADDR_CTRL1, 8'h00},
    '{`SPM_ADDR_CTRL2, 8'h00}, '{`SPM_ADDR_BAUD, 8'h00},
    '{`SPM_ADDR_STATUS, 8'h02}, '{`SPM_ADDR_DATA, 8'h00},
    '{`SPM_ADDR_MASK, 8'h07}, '{8'h18, 8'h00}};

  always #5 clk = ~clk;

  spm_core u_spm_core (
    .I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_WAIT(wt), .I_STOP(stp),
    .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE(sck_oe), .I_MOSI(mosi_w),
    .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe), .I_MISO(miso_w),
    .O_MISO(miso_o), .O_MISO_OE(miso_oe), .I_SS_N(p_ss_n & flt_n),
    .O_IRQ(irq));

  spm_partner u_spm_partner (
    .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .o_sck(p_sck),
    .o_mosi(p_mosi), .o_miso(p_miso), .o_ss_n(p_ss_n));

  // ==========================================================
  // Checking and bus tasks
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Callers enter just after a rising edge
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask : rchk

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("wrong value at %0t: interrupt never came", $time);
      conclude();
    end
  endtask : wait_irq

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) rchk(rows[i].a, rows[i].e);
    chk({7'h00, irq}, 8'h00);
    wreg(`SPM_ADDR_CTRL1, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wreg(`SPM_ADDR_MASK, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Slave byte, then status read and data read to clear
    wreg(`SPM_ADDR_MASK, 8'h01);
    wreg(`SPM_ADDR_DATA, 8'hA5);
    u_spm_partner.xfer(8'h3C, 80, rx);
    @(posedge clk);
    chk(rx, 8'hA5);
    wait_irq(50);
    rchk(`SPM_ADDR_STATUS, 8'h03);
    rchk(`SPM_ADDR_DATA, 8'h3C);
    rchk(`SPM_ADDR_STATUS, 8'h02);
    // Slave in wait with empty buffer echoes the previous byte
    wreg(`SPM_ADDR_CTRL2, 8'h01);
    wt <= 1'b1;
    @(posedge clk);
    u_spm_partner.xfer(8'h11, 80, rx);
    chk(rx, 8'h3C);
    // Let the deselect reach the core before the next frame
    repeat (8) @(posedge clk);
    u_spm_partner.xfer(8'h22, 200, rx);
    chk(rx, 8'h11);
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wt <= 1'b0;
    wait_irq(50);
    rchk(`SPM_ADDR_STATUS, 8'h03);
    rchk(`SPM_ADDR_DATA, 8'h22);
    // Master frozen by stop (select clear) and by wait (select set)
    // Half period of 8 clocks leaves room for the return data synchroniser
    wreg(`SPM_ADDR_BAUD, 8'h07);
    wreg(`SPM_ADDR_CTRL1, 8'h03);
    for (m = 8'h00; m < 8'h02; m++) begin
      u_spm_partner.load(8'h5A + m);
      wreg(`SPM_ADDR_CTRL2, m);
      wreg(`SPM_ADDR_DATA, 8'hC3 ^ m);
      repeat (30) @(posedge clk);
      stp <= (m == 8'h00);
      wt <= (m == 8'h01);
      repeat (2) @(posedge clk);
      s = sck_w;
      repeat (40) begin
        @(posedge clk);
        chk({7'h00, sck_w}, {7'h00, s});
      end
      chk({7'h00, irq}, 8'h00);
      stp <= 1'b0;
      wt <= 1'b0;
      wait_irq(200);
      chk(u_spm_partner.s_rx, 8'hC3 ^ m);
      rchk(`SPM_ADDR_STATUS, 8'h03);
      rchk(`SPM_ADDR_DATA, 8'h5A + m);
    end
    // Select pulled low while master with fault detection on
    wreg(`SPM_ADDR_MASK, 8'h04);
    wreg(`SPM_ADDR_CTRL1, 8'h07);
    flt_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h00);
    rchk(`SPM_ADDR_CTRL1, 8'h05);
    flt_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    rchk(`SPM_ADDR_STATUS, 8'h06);
    wreg(`SPM_ADDR_CTRL1, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rchk(`SPM_ADDR_STATUS, 8'h02);
    conclude();
  end
endmodule : spm_core_tb
